// >>> inc/ragc_pkg.sv
/*
 * package for the right-channel gain control timing register bank:
 * register indices and byte addresses, field positions, reset values
 * and timing multipliers.
 * assumes a 32-bit apb bus with one register per aligned word.
 */
package ragc_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0]  IDX_ENABLE        = 8'h5e;
   localparam logic [7:0]  IDX_GAIN_CEILING  = 8'h60;
   localparam logic [7:0]  IDX_ATTACK_TIMING = 8'h61;
   localparam logic [7:0]  IDX_DECAY_TIMING  = 8'h62;
   localparam logic [7:0]  IDX_NOISE_DEB     = 8'h63;
   localparam logic [7:0]  IDX_STATUS        = 8'h68;

   localparam int          ADDR_W            = 12;

   localparam logic [11:0] ADDR_ENABLE       = {2'h0, IDX_ENABLE, 2'h0};
   localparam logic [11:0] ADDR_GAIN_CEILING = {2'h0, IDX_GAIN_CEILING, 2'h0};
   localparam logic [11:0] ADDR_ATTACK       = {2'h0, IDX_ATTACK_TIMING, 2'h0};
   localparam logic [11:0] ADDR_DECAY        = {2'h0, IDX_DECAY_TIMING, 2'h0};
   localparam logic [11:0] ADDR_NOISE_DEB    = {2'h0, IDX_NOISE_DEB, 2'h0};
   localparam logic [11:0] ADDR_STATUS       = {2'h0, IDX_STATUS, 2'h0};

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_ENABLE        = 8'h00;
   localparam logic [7:0]  RST_GAIN_CEILING  = 8'h7f;
   localparam logic [7:0]  RST_ATTACK        = 8'h00;
   localparam logic [7:0]  RST_DECAY         = 8'h00;
   localparam logic [7:0]  RST_NOISE_DEB     = 8'h00;

   // ==========================================================
   // writable bit masks; reserved bits stay zero
   localparam logic [7:0]  WMASK_ENABLE      = 8'h80;
   localparam logic [7:0]  WMASK_GAIN        = 8'h7f;
   localparam logic [7:0]  WMASK_TIMING      = 8'hff;
   localparam logic [7:0]  WMASK_NOISE       = 8'h1f;

   // ==========================================================
   // field positions
   localparam int          EN_BIT            = 7;
   localparam int          TIME_LSB          = 3;
   localparam int          SCALE_LSB         = 0;

   // ==========================================================
   // limits and timing multipliers, in adc word clocks
   localparam logic [6:0]  GAIN_MAX_CODE     = 7'h74;
   localparam int          ATTACK_BASE_SHIFT = 5;
   localparam int          DECAY_BASE_SHIFT  = 9;
   localparam logic [4:0]  NOISE_LOG_FIRST   = 5'h04;
   localparam logic [4:0]  NOISE_LOG_LAST    = 5'h0a;
   localparam logic [4:0]  NOISE_LIN_BASE    = 5'h0a;
   localparam logic [4:0]  NOISE_LIN_MAX     = 5'h14;
   localparam int          NOISE_LIN_SHIFT   = 12;
   localparam int          NOISE_CODE2_CLKS  = 4;
   localparam int          NOISE_CODE3_CLKS  = 8;

endpackage

// >>> src/ragc_cfg_reg.sv
/*
 * one software-writable configuration register with a reset value
 * and a mask of writable bits.
 * assumes a synchronous, active-low reset and a one-cycle write strobe.
 */
`timescale 1ns/10ps

module ragc_cfg_reg #(
   parameter int             WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET = '0,
   parameter logic [WIDTH-1:0] WMASK = '1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // write side
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wdata,
   // stored value
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] val_d;
   logic [WIDTH-1:0] val_q;

   // ==========================================================
   // next value
   // bits outside the mask load zero on a write so reserved bits read as zero
   always_comb begin
      val_d = val_q;
      if (wr_en) begin
         val_d = wdata & WMASK;
      end
   end

   // ==========================================================
   // storage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         val_q <= RESET;
      end else begin
         val_q <= val_d;
      end
   end

   assign q = val_q;

endmodule

// >>> src/ragc_timing_regs.sv
/*
 * right-channel gain control timing and limit register bank on apb,
 * decoding the stored codes into a gain ceiling and attack, decay and
 * noise debounce times counted in adc word clocks.
 * assumes an apb master on SYS_CLK and a gain loop that reads the
 * decoded outputs; the loop itself lives elsewhere.
 */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps

module ragc_timing_regs #(
   parameter int ATK_W   = 18,
   parameter int DCY_W   = 22,
   parameter int NOISE_W = 17
) (
   // clock and reset
   input  wire logic               SYS_CLK,
   input  wire logic               RST_N,
   // apb slave
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [11:0]        PADDR,
   input  wire logic [31:0]        PWDATA,
   output logic      [31:0]        PRDATA,
   output logic                    PREADY,
   output logic                    PSLVERR,
   // decoded settings for the gain loop
   output logic                    AGC_ACTIVE,
   output logic      [6:0]         MAX_GAIN_CODE,
   output logic      [ATK_W-1:0]   ATTACK_CLKS,
   output logic      [DCY_W-1:0]   DECAY_CLKS,
   output logic      [NOISE_W-1:0] NOISE_DEB_CLKS
);

   // ==========================================================
   // elaboration checks
   // widths must hold 63*32*128, 63*512*128 and 20*4096
   if (ATK_W < 18 || DCY_W < 22 || NOISE_W < 17) begin : g_width_chk
      $error("ragc_timing_regs: output widths too narrow");
   end

   // ==========================================================
   // apb decode
   logic       acc;
   logic       wr;
   logic       hit_en;
   logic       hit_gain;
   logic       hit_atk;
   logic       hit_dcy;
   logic       hit_noise;
   logic       hit_stat;
   logic       mapped;
   logic [7:0] wbyte;

   assign acc   = PSEL && PENABLE;
   assign wr    = acc && PWRITE;
   assign wbyte = PWDATA[7:0];

   always_comb begin
      hit_en    = 1'b0;
      hit_gain  = 1'b0;
      hit_atk   = 1'b0;
      hit_dcy   = 1'b0;
      hit_noise = 1'b0;
      hit_stat  = 1'b0;
      if (PADDR == ragc_pkg::ADDR_ENABLE) begin
         hit_en = 1'b1;
      end else if (PADDR == ragc_pkg::ADDR_GAIN_CEILING) begin
         hit_gain = 1'b1;
      end else if (PADDR == ragc_pkg::ADDR_ATTACK) begin
         hit_atk = 1'b1;
      end else if (PADDR == ragc_pkg::ADDR_DECAY) begin
         hit_dcy = 1'b1;
      end else if (PADDR == ragc_pkg::ADDR_NOISE_DEB) begin
         hit_noise = 1'b1;
      end else if (PADDR == ragc_pkg::ADDR_STATUS) begin
         hit_stat = 1'b1;
      end
   end

   assign mapped = hit_en || hit_gain || hit_atk || hit_dcy || hit_noise || hit_stat;

   // zero wait states: every access completes in its first access cycle
   assign PREADY  = 1'b1;
   assign PSLVERR = acc && !mapped;

   // ==========================================================
   // stored registers
   logic [7:0] enable_reg;
   logic [7:0] gain_reg;
   logic [7:0] attack_reg;
   logic [7:0] decay_reg;
   logic [7:0] noise_reg;

   ragc_cfg_reg #(
      .WIDTH (8),
      .RESET (ragc_pkg::RST_ENABLE),
      .WMASK (ragc_pkg::WMASK_ENABLE)
   ) u_enable (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .wr_en (wr && hit_en),
      .wdata (wbyte),
      .q     (enable_reg)
   );

   ragc_cfg_reg #(
      .WIDTH (8),
      .RESET (ragc_pkg::RST_GAIN_CEILING),
      .WMASK (ragc_pkg::WMASK_GAIN)
   ) u_gain (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .wr_en (wr && hit_gain),
      .wdata (wbyte),
      .q     (gain_reg)
   );

   ragc_cfg_reg #(
      .WIDTH (8),
      .RESET (ragc_pkg::RST_ATTACK),
      .WMASK (ragc_pkg::WMASK_TIMING)
   ) u_attack (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .wr_en (wr && hit_atk),
      .wdata (wbyte),
      .q     (attack_reg)
   );

   ragc_cfg_reg #(
      .WIDTH (8),
      .RESET (ragc_pkg::RST_DECAY),
      .WMASK (ragc_pkg::WMASK_TIMING)
   ) u_decay (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .wr_en (wr && hit_dcy),
      .wdata (wbyte),
      .q     (decay_reg)
   );

   ragc_cfg_reg #(
      .WIDTH (8),
      .RESET (ragc_pkg::RST_NOISE_DEB),
      .WMASK (ragc_pkg::WMASK_NOISE)
   ) u_noise (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .wr_en (wr && hit_noise),
      .wdata (wbyte),
      .q     (noise_reg)
   );

   // ==========================================================
   // decode of stored codes
   logic               en_c;
   logic [6:0]         gain_c;
   logic [ATK_W-1:0]   atk_c;
   logic [DCY_W-1:0]   dcy_c;
   logic [NOISE_W-1:0] noise_c;
   logic [4:0]         atk_n;
   logic [2:0]         atk_s;
   logic [4:0]         dcy_n;
   logic [2:0]         dcy_s;
   logic [4:0]         nz;

   assign en_c  = enable_reg[ragc_pkg::EN_BIT];
   assign atk_n = attack_reg[ragc_pkg::TIME_LSB +: 5];
   assign atk_s = attack_reg[ragc_pkg::SCALE_LSB +: 3];
   assign dcy_n = decay_reg[ragc_pkg::TIME_LSB +: 5];
   assign dcy_s = decay_reg[ragc_pkg::SCALE_LSB +: 3];
   assign nz    = noise_reg[4:0];

   always_comb begin
      if (gain_reg[6:0] > ragc_pkg::GAIN_MAX_CODE) begin
         gain_c = ragc_pkg::GAIN_MAX_CODE;
      end else begin
         gain_c = gain_reg[6:0];
      end
   end

   // base times scale
   // the odd factor is {n,1}, so the product is a pure shift
   always_comb begin
      atk_c = ATK_W'({atk_n, 1'b1}) << (ragc_pkg::ATTACK_BASE_SHIFT + int'(atk_s));
   end

   always_comb begin
      dcy_c = DCY_W'({dcy_n, 1'b1}) << (ragc_pkg::DECAY_BASE_SHIFT + int'(dcy_s));
   end

   always_comb begin
      noise_c = '0;
      if (nz == 5'h02) begin
         noise_c = NOISE_W'(ragc_pkg::NOISE_CODE2_CLKS);
      end else if (nz == 5'h03) begin
         noise_c = NOISE_W'(ragc_pkg::NOISE_CODE3_CLKS);
      end else if (nz >= ragc_pkg::NOISE_LOG_FIRST && nz <= ragc_pkg::NOISE_LOG_LAST) begin
         noise_c = NOISE_W'(1) << (int'(nz) + 1);
      end else if (nz > ragc_pkg::NOISE_LOG_LAST) begin
         if (nz - ragc_pkg::NOISE_LIN_BASE > ragc_pkg::NOISE_LIN_MAX) begin
            noise_c = NOISE_W'(ragc_pkg::NOISE_LIN_MAX) << ragc_pkg::NOISE_LIN_SHIFT;
         end else begin
            noise_c = NOISE_W'(5'(nz - ragc_pkg::NOISE_LIN_BASE)) << ragc_pkg::NOISE_LIN_SHIFT;
         end
      end
   end

   // ==========================================================
   // registered outputs to the gain loop
   logic               active_d;
   logic               active_q;
   logic [6:0]         gain_d;
   logic [6:0]         gain_q;
   logic [ATK_W-1:0]   atk_d;
   logic [ATK_W-1:0]   atk_q;
   logic [DCY_W-1:0]   dcy_d;
   logic [DCY_W-1:0]   dcy_q;
   logic [NOISE_W-1:0] noise_d;
   logic [NOISE_W-1:0] noise_q;

   // gated by enable
   // a disabled loop sees all zeros so nothing stale drives it
   always_comb begin
      active_d = en_c;
      gain_d   = '0;
      atk_d    = '0;
      dcy_d    = '0;
      noise_d  = '0;
      if (en_c) begin
         gain_d  = gain_c;
         atk_d   = atk_c;
         dcy_d   = dcy_c;
         noise_d = noise_c;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         active_q <= 1'b0;
         gain_q   <= '0;
         atk_q    <= '0;
         dcy_q    <= '0;
         noise_q  <= '0;
      end else begin
         active_q <= active_d;
         gain_q   <= gain_d;
         atk_q    <= atk_d;
         dcy_q    <= dcy_d;
         noise_q  <= noise_d;
      end
   end

   assign AGC_ACTIVE     = active_q;
   assign MAX_GAIN_CODE  = gain_q;
   assign ATTACK_CLKS    = atk_q;
   assign DECAY_CLKS     = dcy_q;
   assign NOISE_DEB_CLKS = noise_q;

   // ==========================================================
   // read mux
   // status shows the active flag and gain ceiling the loop really gets, clamp and gating included
   logic [31:0] rdata_mux;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   always_comb begin
      rdata_mux = '0;
      if (hit_en) begin
         rdata_mux = {24'h000000, enable_reg};
      end else if (hit_gain) begin
         rdata_mux = {24'h000000, gain_reg};
      end else if (hit_atk) begin
         rdata_mux = {24'h000000, attack_reg};
      end else if (hit_dcy) begin
         rdata_mux = {24'h000000, decay_reg};
      end else if (hit_noise) begin
         rdata_mux = {24'h000000, noise_reg};
      end else if (hit_stat) begin
         rdata_mux = {24'h000000, active_q, gain_q};
      end
   end

   // captured at the end of setup so read data come from a flop
   // and still stand through the access cycle with no wait state
   always_comb begin
      rdata_d = rdata_q;
      if (PSEL && !PENABLE && !PWRITE) begin
         rdata_d = rdata_mux;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign PRDATA = rdata_q;

endmodule

// >>> testbench/ragc_properties.sv
/* checker for the gain control timing bank.
   assumes the bank's apb and decoded output ports. */
`timescale 1ns/10ps
module ragc_props #(
   parameter int ATK_W   = 18,
   parameter int DCY_W   = 22,
   parameter int NOISE_W = 17
) (
   // clock and reset
   input wire logic               SYS_CLK,
   input wire logic               RST_N,
   // apb
   input wire logic               PSEL,
   input wire logic               PENABLE,
   input wire logic               PWRITE,
   input wire logic [11:0]        PADDR,
   input wire logic [31:0]        PWDATA,
   input wire logic [31:0]        PRDATA,
   input wire logic               PREADY,
   input wire logic               PSLVERR,
   // decoded settings
   input wire logic               AGC_ACTIVE,
   input wire logic [6:0]         MAX_GAIN_CODE,
   input wire logic [ATK_W-1:0]   ATTACK_CLKS,
   input wire logic [DCY_W-1:0]   DECAY_CLKS,
   input wire logic [NOISE_W-1:0] NOISE_DEB_CLKS
);
   wire logic wr = PSEL && PENABLE && PWRITE;
   wire logic rd = PSEL && PENABLE && !PWRITE;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // ==========
   // outputs follow a stored write two edges on
   a_gain_value:
   assert property (wr && PADDR == ragc_pkg::ADDR_GAIN_CEILING |-> ##2 (!AGC_ACTIVE || MAX_GAIN_CODE ==
      (($past(PWDATA[6:0], 2) > 7'h74) ? 7'h74 : $past(PWDATA[6:0], 2)))) else $error("gain ceiling wrong");
   a_atk_value:
   assert property (wr && PADDR == ragc_pkg::ADDR_ATTACK |-> ##2 (!AGC_ACTIVE || ATTACK_CLKS ==
      ((($past(PWDATA[7:3], 2) * 2 + 1) * 32) << $past(PWDATA[2:0], 2)))) else $error("attack time wrong");
   a_dcy_value:
   assert property (wr && PADDR == ragc_pkg::ADDR_DECAY |-> ##2 (!AGC_ACTIVE || DECAY_CLKS ==
      ((($past(PWDATA[7:3], 2) * 2 + 1) * 512) << $past(PWDATA[2:0], 2)))) else $error("decay time wrong");
   a_noise_low:
   assert property (wr && PADDR == ragc_pkg::ADDR_NOISE_DEB && PWDATA[4:1] == 0 |-> ##2 NOISE_DEB_CLKS == 0)
      else $error("noise zero code wrong");
   a_noise_top:
   assert property (NOISE_DEB_CLKS <= 20 * 4096) else $error("noise time above top");
   a_idle_zero:
   assert property (!AGC_ACTIVE |-> MAX_GAIN_CODE == 0 && ATTACK_CLKS == 0 && DECAY_CLKS == 0
      && NOISE_DEB_CLKS == 0) else $error("settings act while disabled");
   a_rsvd_gain:
   assert property (rd && PADDR == ragc_pkg::ADDR_GAIN_CEILING |-> PRDATA[31:7] == 0) else $error("gain top bit");
   a_rsvd_noise:
   assert property (rd && PADDR == ragc_pkg::ADDR_NOISE_DEB |-> PRDATA[31:5] == 0) else $error("noise top bits");
endmodule

bind ragc_timing_regs ragc_props #(.ATK_W(ATK_W), .DCY_W(DCY_W), .NOISE_W(NOISE_W)) u_props (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .AGC_ACTIVE(AGC_ACTIVE),
   .MAX_GAIN_CODE(MAX_GAIN_CODE), .ATTACK_CLKS(ATTACK_CLKS), .DECAY_CLKS(DECAY_CLKS),
   .NOISE_DEB_CLKS(NOISE_DEB_CLKS));

// >>> testbench/ragc_timing_regs_tb.sv
/* self-checking bench for the gain control timing bank.
   assumes the bank answers apb, waits bounded by the watchdog. */
`timescale 1ns/10ps
module ragc_timing_regs_tb;
   // ==========
   // bench signals
   logic        SYS_CLK = 0;
   logic        RST_N   = 0;
   logic        PSEL    = 0;
   logic        PENABLE = 0;
   logic        PWRITE  = 0;
   logic [11:0] PADDR   = '0;
   logic [31:0] PWDATA  = '0;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        AGC_ACTIVE;
   logic [6:0]  MAX_GAIN_CODE;
   logic [17:0] ATTACK_CLKS;
   logic [21:0] DECAY_CLKS;
   logic [16:0] NOISE_DEB_CLKS;
   logic [31:0] rd_data;
   logic        err_bit;
   int          num_errors = 0;
   int          n_compared = 0;

   ragc_timing_regs uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .AGC_ACTIVE(AGC_ACTIVE), .MAX_GAIN_CODE(MAX_GAIN_CODE),
      .ATTACK_CLKS(ATTACK_CLKS), .DECAY_CLKS(DECAY_CLKS), .NOISE_DEB_CLKS(NOISE_DEB_CLKS));

   initial begin
      forever #4 SYS_CLK = ~SYS_CLK;
   end

   // ==========
   // shared tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // an idle cycle before each setup keeps psel from being assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge SYS_CLK);
      end while (PREADY !== 1'b1);
      rd_data = PRDATA;
      err_bit = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, '0);
      check(nm, rd_data, e);
      check({nm, " error"}, err_bit, 1'b0);
   endtask

   // decoded outputs trail the stored register by one edge
   task automatic settle;
      repeat (2) @(posedge SYS_CLK);
      #1;
   endtask

   // ==========
   // scenarios
   task automatic t_reset;
      rd_chk(ragc_pkg::ADDR_GAIN_CEILING, 32'h7f, "gain reset");
      rd_chk(ragc_pkg::ADDR_ATTACK, 32'h0, "attack reset");
      rd_chk(ragc_pkg::ADDR_DECAY, 32'h0, "decay reset");
      rd_chk(ragc_pkg::ADDR_NOISE_DEB, 32'h0, "noise reset");
      check("active reset", AGC_ACTIVE, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_timing;
      int n;
      int s;
      wr(ragc_pkg::ADDR_ATTACK, 32'hff);
      settle;
      check("attack off", ATTACK_CLKS, 0);
      wr(ragc_pkg::ADDR_ENABLE, 32'h80);
      for (s = 0; s < 8; s++) begin
         n = (s == 7) ? 31 : s * 4;
         wr(ragc_pkg::ADDR_ATTACK, (n << 3) | s);
         wr(ragc_pkg::ADDR_DECAY, ((31 - n) << 3) | s);
         settle;
         rd_chk(ragc_pkg::ADDR_DECAY, ((31 - n) << 3) | s, "decay read");
         check("attack", ATTACK_CLKS, ((2 * n + 1) * 32) << s);
         check("decay", DECAY_CLKS, ((63 - 2 * n) * 512) << s);
      end
      $display("test timing done");
   endtask

   task automatic t_gain;
      logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h73, 8'h74, 8'h75, 8'h7f, 8'hff};
      foreach (codes[i]) begin
         wr(ragc_pkg::ADDR_GAIN_CEILING, {24'h0, codes[i]});
         settle;
         rd_chk(ragc_pkg::ADDR_GAIN_CEILING, {25'h0, codes[i][6:0]}, "gain read");
         check("gain", MAX_GAIN_CODE, (codes[i][6:0] > 7'h74) ? 7'h74 : codes[i][6:0]);
         rd_chk(ragc_pkg::ADDR_STATUS, {24'h0, 1'b1, (codes[i][6:0] > 7'h74) ? 7'h74 : codes[i][6:0]}, "status");
      end
      $display("test gain done");
   endtask

   task automatic t_noise;
      int c;
      int e;
      for (c = 0; c < 32; c++) begin
         if (c < 2) e = 0;
         else if (c < 4) e = (c - 1) * 4;
         else if (c < 11) e = 1 << (c + 1);
         else if (c < 30) e = (c - 10) * 4096;
         else e = 20 * 4096;
         wr(ragc_pkg::ADDR_NOISE_DEB, 32'he0 | c);
         settle;
         rd_chk(ragc_pkg::ADDR_NOISE_DEB, c, "noise read");
         check("noise", NOISE_DEB_CLKS, e);
      end
      $display("test noise done");
   endtask

   task automatic t_off;
      apb(1'b0, 12'h000, '0);
      check("unmapped read", rd_data, 0);
      check("unmapped error", err_bit, 1'b1);
      wr(ragc_pkg::ADDR_ENABLE, 0);
      settle;
      check("active off", AGC_ACTIVE, 0);
      check("decay off", DECAY_CLKS, 0);
      check("noise off", NOISE_DEB_CLKS, 0);
      check("gain off", MAX_GAIN_CODE, 0);
      check("attack off2", ATTACK_CLKS, 0);
      rd_chk(ragc_pkg::ADDR_STATUS, 32'h0, "status off");
      $display("test off done");
   endtask

   // reset in mid-run returns the gain ceiling and enable registers to their reset values
   task automatic t_rerst;
      wr(ragc_pkg::ADDR_GAIN_CEILING, 32'h10);
      wr(ragc_pkg::ADDR_ENABLE, 32'h80);
      @(posedge SYS_CLK);
      RST_N <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      rd_chk(ragc_pkg::ADDR_GAIN_CEILING, 32'h7f, "gain rerst");
      rd_chk(ragc_pkg::ADDR_ENABLE, 32'h0, "enable rerst");
      check("active rerst", AGC_ACTIVE, 1'b0);
      $display("test rerst done");
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      t_reset;
      t_timing;
      t_gain;
      t_noise;
      t_off;
      t_rerst;
      finish_test;
   end

   // about twenty-five times the expected run
   initial begin
      #100000;
      num_errors++;
      finish_test;
   end
endmodule
